/* pkg/lane_cfg_pkg.sv */
// Purpose: Constants for the lane output and detect configuration bank
// Assumes: Byte registers on a 32-bit classic Wishbone bus, one word each
// Notes: Register index times four gives the byte address
package lane_cfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register indices
  localparam logic [7:0] IDX_DEEMPHASIS = 8'h26;
  localparam logic [7:0] IDX_DETECT_THRESHOLD = 8'h27;
  localparam logic [7:0] IDX_DETECT_CONTROL = 8'h28;
  localparam logic [7:0] IDX_RESERVED_A = 8'h29;
  localparam logic [7:0] IDX_RESERVED_B = 8'h2a;
  localparam logic [7:0] IDX_OVERRIDE = 8'h08;
  // Reset values
  localparam logic [7:0] RST_DEEMPHASIS = 8'h02;
  localparam logic [7:0] RST_DETECT_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_DETECT_CONTROL = 8'h4c;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  // Field positions
  localparam int unsigned POS_TERM_DETECT = 7;
  localparam int unsigned POS_DEEMPH_LSB = 0;
  localparam int unsigned POS_ASSERT_LSB = 2;
  localparam int unsigned POS_DEASSERT_LSB = 0;
  localparam int unsigned POS_OVERRIDE = 6;
  localparam int unsigned POS_HIGH_RANGE_LO = 5;
  localparam int unsigned POS_HIGH_RANGE_HI = 4;
  localparam int unsigned POS_FAST_LO = 3;
  localparam int unsigned POS_FAST_HI = 2;
  localparam int unsigned POS_REDUCED_LO = 1;
  localparam int unsigned POS_REDUCED_HI = 0;
  // Writable masks
  localparam logic [7:0] MASK_DEEMPHASIS = 8'h07;
  localparam logic [7:0] MASK_DETECT_THRESHOLD = 8'h0f;
  localparam logic [7:0] MASK_DETECT_CONTROL = 8'hff;
  localparam logic [7:0] MASK_OVERRIDE = 8'hff;
  // Decoded settings in tenths of dB and mVp-p
  localparam logic [7:0] DEEMPH_TENTHS_DB [8] = '{8'd0, 8'd15, 8'd35, 8'd50,
                                                 8'd60, 8'd80, 8'd90, 8'd120};
  localparam logic [7:0] ASSERT_MV [4] = '{8'd50, 8'd40, 8'd75, 8'd58};
  localparam logic [7:0] DEASSERT_MV [4] = '{8'd37, 8'd22, 8'd55, 8'd45};
  localparam int unsigned SYNC_STAGES = 3;
endpackage : lane_cfg_pkg

/* rtl/lane_output_and_detect_config.sv */
// Purpose: Register bank for one lane's de-emphasis and detect thresholds
// Assumes: Classic Wishbone slave, 32-bit data, registers in byte lane 0
// Notes: Analog settings leave as decoded codes and flags

// Behaviour
// - Bit 7 of the de-emphasis register reads the live termination-detect result.
// - The 3-bit de-emphasis field decodes 0 to -12 dB and resets to 010.
// - The assert threshold field in bits 3:2 decodes 50/40/75/58 mVp-p, default 00.
// - The de-assert threshold field in bits 1:0 decodes 37/22/55/45 mVp-p, default 00.
// - Register thresholds apply only while override bit 6 of register 0x08 is set.
// - Detect control bits 5 and 4 enable high threshold range for lanes 0-3 and 4-7.
// - Detect control bits 3 and 2 enable fast detection for lanes 0-3 and 4-7.
// - Detect control bits 1 and 0 enable reduced detect gain for lanes 0-3 and 4-7.
module lane_output_and_detect_config #(
  parameter int unsigned LANE_GROUP = 0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_wb_err,
  input wire logic i_termination_detect,
  input wire logic [1:0] i_threshold_pin_assert,
  input wire logic [1:0] i_threshold_pin_deassert,
  output logic [2:0] o_output_deemphasis,
  output logic [7:0] o_deemphasis_tenths_db,
  output logic [1:0] o_assert_threshold,
  output logic [1:0] o_deassert_threshold,
  output logic [7:0] o_assert_mv,
  output logic [7:0] o_deassert_mv,
  output logic o_threshold_from_register,
  output logic o_high_range,
  output logic o_fast_detect,
  output logic o_reduced_gain
);
  // Only two lane groups share the control register
  if (LANE_GROUP > 1) begin : g_bad_group
    $error("LANE_GROUP must be 0 or 1");
  end

  typedef struct packed {
    logic [7:0] deemphasis;
    logic [7:0] threshold;
    logic [7:0] control;
    logic [7:0] override;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic [2:0] out_deemph;
    logic [1:0] out_assert;
    logic [1:0] out_deassert;
    logic [7:0] assert_mv;
    logic [7:0] deassert_mv;
    logic [7:0] deemph_db;
    logic from_reg;
    logic high_range;
    logic fast;
    logic reduced;
  } bank_s;

  bank_s state;
  bank_s next_state;
  logic term_level;
  logic request;
  logic [7:0] index;
  logic known;

  // Pin level arrives from the analog detector, outside the clock domain
  pin_sync u_term_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_termination_detect),
    .o_level(term_level)
  );

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction : merge

  function automatic logic pick(input logic [7:0] ctl, input int unsigned lo_pos,
                                input int unsigned hi_pos);
    pick = (LANE_GROUP == 0) ? ctl[lo_pos] : ctl[hi_pos];
  endfunction : pick

  assign request = i_wb_cyc && i_wb_stb && !state.ack && !state.err;
  assign index = i_wb_adr[9:2];
  assign known = (index == lane_cfg_pkg::IDX_DEEMPHASIS)
              || (index == lane_cfg_pkg::IDX_DETECT_THRESHOLD)
              || (index == lane_cfg_pkg::IDX_DETECT_CONTROL)
              || (index == lane_cfg_pkg::IDX_RESERVED_A)
              || (index == lane_cfg_pkg::IDX_RESERVED_B)
              || (index == lane_cfg_pkg::IDX_OVERRIDE);

  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.err = 1'b0;
    if (request) begin
      next_state.ack = known;
      next_state.err = !known;
      next_state.rdata = 32'h0000_0000;
      if (known && i_wb_we && i_wb_sel[0]) begin
        unique case (index)
          lane_cfg_pkg::IDX_DEEMPHASIS: begin
            // Bit 7 is not stored
            next_state.deemphasis = merge(state.deemphasis, i_wb_dat[7:0],
                                          lane_cfg_pkg::MASK_DEEMPHASIS);
          end
          lane_cfg_pkg::IDX_DETECT_THRESHOLD: begin
            next_state.threshold = merge(state.threshold, i_wb_dat[7:0],
                                         lane_cfg_pkg::MASK_DETECT_THRESHOLD);
          end
          lane_cfg_pkg::IDX_DETECT_CONTROL: begin
            next_state.control = merge(state.control, i_wb_dat[7:0],
                                       lane_cfg_pkg::MASK_DETECT_CONTROL);
          end
          lane_cfg_pkg::IDX_OVERRIDE: begin
            next_state.override = merge(state.override, i_wb_dat[7:0],
                                        lane_cfg_pkg::MASK_OVERRIDE);
          end
          default: begin
            // Reserved words accept and drop writes
          end
        endcase
      end
      if (known && !i_wb_we) begin
        unique case (index)
          lane_cfg_pkg::IDX_DEEMPHASIS: begin
            next_state.rdata[7:0] = state.deemphasis;
            next_state.rdata[lane_cfg_pkg::POS_TERM_DETECT] = term_level;
          end
          lane_cfg_pkg::IDX_DETECT_THRESHOLD: begin
            next_state.rdata[7:0] = state.threshold;
          end
          lane_cfg_pkg::IDX_DETECT_CONTROL: begin
            next_state.rdata[7:0] = state.control;
          end
          lane_cfg_pkg::IDX_OVERRIDE: begin
            next_state.rdata[7:0] = state.override;
          end
          default: begin
            next_state.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Outputs follow stored fields one cycle later
    next_state.out_deemph = state.deemphasis[lane_cfg_pkg::POS_DEEMPH_LSB +: 3];
    next_state.deemph_db = lane_cfg_pkg::DEEMPH_TENTHS_DB[next_state.out_deemph];
    next_state.from_reg = state.override[lane_cfg_pkg::POS_OVERRIDE];
    if (next_state.from_reg) begin
      next_state.out_assert = state.threshold[lane_cfg_pkg::POS_ASSERT_LSB +: 2];
      next_state.out_deassert = state.threshold[lane_cfg_pkg::POS_DEASSERT_LSB +: 2];
    end else begin
      // Pin straps govern until software takes over
      next_state.out_assert = i_threshold_pin_assert;
      next_state.out_deassert = i_threshold_pin_deassert;
    end
    next_state.assert_mv = lane_cfg_pkg::ASSERT_MV[next_state.out_assert];
    next_state.deassert_mv = lane_cfg_pkg::DEASSERT_MV[next_state.out_deassert];
    next_state.high_range = pick(state.control, lane_cfg_pkg::POS_HIGH_RANGE_LO,
                                 lane_cfg_pkg::POS_HIGH_RANGE_HI);
    next_state.fast = pick(state.control, lane_cfg_pkg::POS_FAST_LO,
                           lane_cfg_pkg::POS_FAST_HI);
    next_state.reduced = pick(state.control, lane_cfg_pkg::POS_REDUCED_LO,
                              lane_cfg_pkg::POS_REDUCED_HI);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= '0;
      state.deemphasis <= lane_cfg_pkg::RST_DEEMPHASIS;
      state.threshold <= lane_cfg_pkg::RST_DETECT_THRESHOLD;
      state.control <= lane_cfg_pkg::RST_DETECT_CONTROL;
      state.override <= lane_cfg_pkg::RST_OVERRIDE;
    end else begin
      state <= next_state;
    end
  end

  // Pin thresholds are not synchronised: treated as static straps
  assign o_wb_dat = state.rdata;
  assign o_wb_ack = state.ack;
  assign o_wb_err = state.err;
  assign o_output_deemphasis = state.out_deemph;
  assign o_deemphasis_tenths_db = state.deemph_db;
  assign o_assert_threshold = state.out_assert;
  assign o_deassert_threshold = state.out_deassert;
  assign o_assert_mv = state.assert_mv;
  assign o_deassert_mv = state.deassert_mv;
  assign o_threshold_from_register = state.from_reg;
  assign o_high_range = state.high_range;
  assign o_fast_detect = state.fast;
  assign o_reduced_gain = state.reduced;
endmodule : lane_output_and_detect_config

/* rtl/pin_sync.sv */
// Purpose: Three-stage synchroniser for a pin level
// Assumes: Input asynchronous to i_clk
// Notes: Output changes only when stages two and three agree
module pin_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_s;
  sync_s state;
  sync_s next_state;

  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[1:0], i_pin};
    // First stage feeds only the second
    if (state.stage[1] == state.stage[2]) begin
      next_state.level = state.stage[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_level = state.level;
endmodule : pin_sync

/* sim/lane_cfg_asserts.sv */
// Purpose: Concurrent checks on the lane config bank ports
// Assumes: One clock, synchronous active-high reset
// Notes: Settings outputs move two edges after a write is taken
module lane_cfg_asserts #(
  parameter int unsigned LANE_GROUP = 0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_wb_err,
  input wire logic [1:0] i_threshold_pin_assert,
  input wire logic [1:0] i_threshold_pin_deassert,
  input wire logic [2:0] o_output_deemphasis,
  input wire logic [7:0] o_deemphasis_tenths_db,
  input wire logic [1:0] o_assert_threshold,
  input wire logic [1:0] o_deassert_threshold,
  input wire logic [7:0] o_assert_mv,
  input wire logic [7:0] o_deassert_mv,
  input wire logic o_threshold_from_register,
  input wire logic o_high_range,
  input wire logic o_fast_detect,
  input wire logic o_reduced_gain
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Write taken: strobe up, no answer pending
  sequence s_wr(logic [9:0] a);
    i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && !o_wb_ack && !o_wb_err && i_wb_adr == a;
  endsequence
  // First edge after release still sees the cleared outputs
  property p_deemph_db;
    !$past(i_reset) |-> o_deemphasis_tenths_db == lane_cfg_pkg::DEEMPH_TENTHS_DB[o_output_deemphasis];
  endproperty
  a_deemph_db: assert property (p_deemph_db) else $error("de-emphasis magnitude off");
  property p_assert_mv;
    !$past(i_reset) |-> o_assert_mv == lane_cfg_pkg::ASSERT_MV[o_assert_threshold];
  endproperty
  a_assert_mv: assert property (p_assert_mv) else $error("assert level off");
  property p_deassert_mv;
    !$past(i_reset) |-> o_deassert_mv == lane_cfg_pkg::DEASSERT_MV[o_deassert_threshold];
  endproperty
  a_deassert_mv: assert property (p_deassert_mv) else $error("de-assert level off");
  property p_pin_sel;
    !$past(i_reset) && !o_threshold_from_register && !$past(o_threshold_from_register)
      |-> o_assert_threshold == i_threshold_pin_assert
      && o_deassert_threshold == i_threshold_pin_deassert;
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pins not governing");
  property p_wr_deemph;
    s_wr(10'h098) |-> ##2 o_output_deemphasis == $past(i_wb_dat[2:0], 2);
  endproperty
  a_wr_deemph: assert property (p_wr_deemph) else $error("de-emphasis not applied");
  property p_high;
    s_wr(10'h0a0) |-> ##2 o_high_range == $past(i_wb_dat[5 - LANE_GROUP], 2);
  endproperty
  a_high: assert property (p_high) else $error("high range not applied");
  property p_fast;
    s_wr(10'h0a0) |-> ##2 o_fast_detect == $past(i_wb_dat[3 - LANE_GROUP], 2);
  endproperty
  a_fast: assert property (p_fast) else $error("fast detect not applied");
  property p_reduced;
    s_wr(10'h0a0) |-> ##2 o_reduced_gain == $past(i_wb_dat[1 - LANE_GROUP], 2);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced gain not applied");
  property p_override_flag;
    s_wr(10'h020) |-> ##2 o_threshold_from_register == $past(i_wb_dat[6], 2);
  endproperty
  a_override_flag: assert property (p_override_flag) else $error("override not applied");
endmodule : lane_cfg_asserts

/* sim/lane_output_and_detect_config_tb.sv */
// Purpose: Self-checking bench for the lane config bank
// Assumes: Lane group 0, threshold pins held static
// Notes: Settings sampled at the falling edge, once updated
module lane_output_and_detect_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_reset = 1'h1, req = 1'h0, i_wb_we = 1'h0, i_termination_detect = 1'h0;
  logic [9:0] i_wb_adr = 10'h000;
  logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat;
  logic [1:0] i_threshold_pin_assert = 2'h3, i_threshold_pin_deassert = 2'h2;
  logic [1:0] o_assert_threshold, o_deassert_threshold;
  logic [2:0] o_output_deemphasis;
  logic [7:0] o_deemphasis_tenths_db, o_assert_mv, o_deassert_mv;
  logic o_wb_ack, o_wb_err, o_threshold_from_register, o_high_range, o_fast_detect, o_reduced_gain;
  int n_mismatch = 0, n_checks = 0;
  always #20 i_clk = ~i_clk;
  lane_output_and_detect_config u_lane_output_and_detect_config (
    .i_clk, .i_reset, .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we, .i_wb_adr, .i_wb_sel(4'h1),
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .i_termination_detect, .i_threshold_pin_assert,
    .i_threshold_pin_deassert, .o_output_deemphasis, .o_deemphasis_tenths_db,
    .o_assert_threshold, .o_deassert_threshold, .o_assert_mv, .o_deassert_mv,
    .o_threshold_from_register, .o_high_range, .o_fast_detect, .o_reduced_gain
  );
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task close_out;
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // One classic cycle; answer taken at the edge that sees it
  task wb(input logic we, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q,
          output logic e);
    int n;
    @(posedge i_clk);
    req <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'h1 && o_wb_err !== 1'h1 && n < 20);
    q = o_wb_dat;
    e = o_wb_err;
    req <= 1'h0;
    if (n >= 20) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
  endtask : wb
  task wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    wb(1'h1, a, {24'h00_0000, d}, q, e);
    @(negedge i_clk);
  endtask : wr
  task rd(input logic [9:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic e;
    wb(1'h0, a, 32'h0000_0000, q, e);
    chk("error flag", {31'h0, ex}, {31'h0, e});
    if (!ex) chk("read data", x, q);
  endtask : rd
  task t_reset;
    rd(10'h098, 32'h0000_0002, 1'h0);
    rd(10'h09c, 32'h0000_0000, 1'h0);
    rd(10'h0a0, 32'h0000_004c, 1'h0);
    wr(10'h0a4, 8'hff);
    rd(10'h0a4, 32'h0000_0000, 1'h0);
    rd(10'h3fc, 32'h0000_0000, 1'h1);
    chk("ctl flags", 32'h0000_0002, 32'({o_high_range, o_fast_detect, o_reduced_gain}));
  endtask : t_reset
  // Top bits set on purpose: only the code may stick
  task t_deemph;
    for (int c = 0; c < 8; c++) begin
      wr(10'h098, 8'hf8 | 8'(c));
      rd(10'h098, 32'(c), 1'h0);
      chk("db code", 32'(c), 32'(o_output_deemphasis));
      chk("db tenths", 32'(lane_cfg_pkg::DEEMPH_TENTHS_DB[c]), 32'(o_deemphasis_tenths_db));
    end
  endtask : t_deemph
  task t_term;
    i_termination_detect <= 1'h1;
    repeat (6) @(posedge i_clk);
    rd(10'h098, 32'h0000_0087, 1'h0);
    wr(10'h098, 8'h02);
    rd(10'h098, 32'h0000_0082, 1'h0);
    i_termination_detect <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(10'h098, 32'h0000_0002, 1'h0);
  endtask : t_term
  task t_thresh;
    wr(10'h09c, 8'hf7);
    rd(10'h09c, 32'h0000_0007, 1'h0);
    chk("pin levels", 32'h0000_3a37, {16'h0000, o_assert_mv, o_deassert_mv});
    wr(10'h020, 8'h40);
    @(negedge i_clk);
    chk("from reg", 32'h0000_0001, 32'(o_threshold_from_register));
    chk("reg codes", 32'h0000_0007, 32'({o_assert_threshold, o_deassert_threshold}));
    chk("reg levels", 32'h0000_282d, {16'h0000, o_assert_mv, o_deassert_mv});
    wr(10'h020, 8'h00);
  endtask : t_thresh
  task t_ctrl;
    wr(10'h0a0, 8'h2a);
    chk("ctl on", 32'h0000_0007, 32'({o_high_range, o_fast_detect, o_reduced_gain}));
    wr(10'h0a0, 8'h15);
    chk("ctl off", 32'h0000_0000, 32'({o_high_range, o_fast_detect, o_reduced_gain}));
    rd(10'h0a0, 32'h0000_0015, 1'h0);
  endtask : t_ctrl
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'h0;
    t_reset;
    t_deemph;
    t_term;
    t_thresh;
    t_ctrl;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    close_out;
  end
endmodule : lane_output_and_detect_config_tb
bind lane_output_and_detect_config lane_cfg_asserts #(.LANE_GROUP(LANE_GROUP)) u_lane_cfg_asserts (
  .i_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack,
  .o_wb_err, .i_threshold_pin_assert, .i_threshold_pin_deassert, .o_output_deemphasis,
  .o_deemphasis_tenths_db, .o_assert_threshold, .o_deassert_threshold, .o_assert_mv,
  .o_deassert_mv, .o_threshold_from_register, .o_high_range, .o_fast_detect, .o_reduced_gain
);
